// ===== core/msof_ctrl.sv
// Purpose: Measurement initiate/abort control, post-processing chain, APB registers
// Assumes: Measurement engine runs on pclk; meas_done is a one-cycle pulse
// Notes: Result reads stall pready during holdoff; every access takes two cycles or more
//
// The address map and the APB register port are this design's own decisions.

// Functional notes
// RULE_01 - Abort stops measurement, completes once engine idle
// RULE_02 - Abort clears the pending-operation flag
// RULE_03 - Idle abort changes nothing
// RULE_04 - Single measurement abort clears pending
// RULE_05 - Continuous abort restarts measurement, sets pending
// RULE_06 - Block abort terminates whole block
// RULE_07 - Abort clears measuring status bit
// RULE_08 - Aborted measurement invalidates result
// RULE_09 - New data runs all three stages
// RULE_10 - Result valid until recomputed or config change
// RULE_11 - Stage three: two serial sub-blocks, reportable
// RULE_12 - Voltage-peak function bypasses all stages
// RULE_13 - Each stage ignored until enabled
// RULE_14 - Math is value times scale plus offset
// RULE_15 - No valid result: NaN, no-data error
// RULE_16 - Voltage-peak query: NaN, conflict error
// RULE_17 - Text result has one to fifteen digits
// RULE_18 - Math result query held during measurement
// RULE_19 - Recalculate reruns stages one, two only
// RULE_20 - Auto recalc reruns after config commands
// RULE_21 - Auto recalc on at power-up, off by reset
// RULE_22 - Math enable write clears limit counts
// RULE_23 - Boolean query answers ASCII zero or one
// RULE_24 - Equation query must end the message
// RULE_25 - Measuring set while running, cleared on completion
module msof_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msof_pkg::ADDR_W-1:0] paddr,
  input wire logic [msof_pkg::DATA_W-1:0] pwdata,
  output logic [msof_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_busy,
  input wire logic meas_done,
  input wire logic [msof_pkg::DATA_W-1:0] meas_data,
  input wire logic vpeak_active,
  input wire logic dev_clear,
  output logic meas_start,
  output logic meas_abort,
  output logic block_mode,
  output logic pending_flag,
  output logic measuring,
  output logic [msof_pkg::DATA_W-1:0] out_data,
  output logic out_valid
);
  import msof_pkg::*;

  typedef struct packed {
    logic cont;
    logic atc;
    logic avg;
    logic autorc;
    logic lim_en;
    logic lfil_en;
    logic [3:0] resol;
    logic math_en;
    logic [DATA_W-1:0] scale;
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] lower;
    logic [DATA_W-1:0] upper;
    logic pending;
    logic measuring;
    logic abort_wait;
    logic start_q;
    logic abort_q;
    logic calc_req;
    logic [DATA_W-1:0] raw;
    logic result_valid;
    logic last_fail;
    logic [CNT_W-1:0] fail_cnt;
    logic [CNT_W-1:0] pass_cnt;
    logic [15:0] err;
    logic waited;
    logic [DATA_W-1:0] rdata;
  } msof_st_type;

  localparam msof_st_type ST_RST = '{
    autorc: AUTORC_POWERUP, math_en: MATH_RST, scale: SCALE_RST, offset: OFFSET_RST,
    lower: LOWER_RST, upper: UPPER_RST, default: '0};

  msof_st_type st_reg;
  msof_st_type st_next;
  logic setup;
  logic access;
  logic rd_res;
  logic rd_rc;
  logic hold_math;
  logic hold_calc;
  logic stall;
  logic xfer;
  logic mapped;
  logic eff_math;
  logic eff_lim;
  logic acq;
  logic calc_go;
  logic [DATA_W-1:0] m_res;
  logic m_done;
  logic m_acq;
  logic [DATA_W-1:0] rd_val;
  logic [7:0] path_code;
  logic [3:0] digits;
  logic out_range;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign rd_res = ~pwrite & (paddr == OFS_RESULT);
  assign rd_rc = ~pwrite & (paddr == OFS_RECALC);
  // Holdoff ends only by completion or device clear; see RULE_18
  // Result lands the cycle after completion, so hold through the math pass too
  assign hold_math = access & (rd_res | rd_rc) & st_reg.math_en & (st_reg.measuring | m_done) &
                     ~dev_clear;
  // Recalculate query waits for its own new result; see RULE_19
  assign hold_calc = access & rd_rc & (st_reg.calc_req | m_done);
  // Commands after an abort wait until the engine has stopped; see RULE_01
  assign stall = hold_math | hold_calc | (access & st_reg.abort_wait);
  assign pready = access & st_reg.waited & ~stall;
  assign xfer = access & pready;
  assign pslverr = pready & ~mapped;

  // Voltage-peak function bypasses every stage; see RULE_12
  assign eff_math = st_reg.math_en & ~vpeak_active; // see RULE_13
  assign eff_lim = st_reg.lim_en & ~vpeak_active; // see RULE_13
  // Results of an aborted measurement are dropped
  assign acq = meas_done & st_reg.measuring & ~st_reg.abort_wait;
  assign calc_go = acq | st_reg.calc_req; // see RULE_09
  assign digits = (st_reg.resol < DIGITS_MIN) ? DIGITS_MIN : st_reg.resol; // see RULE_17
  assign out_range = ($signed(m_res) < $signed(st_reg.lower)) |
                     ($signed(m_res) > $signed(st_reg.upper));

  msof_math u_math (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .calc(calc_go),
    .calc_acq(acq),
    .math_on(eff_math),
    .din(acq ? meas_data : st_reg.raw),
    .scale(st_reg.scale),
    .offset(st_reg.offset),
    .result(m_res),
    .done(m_done),
    .done_acq(m_acq)
  );

  // Only fresh acquisitions reach stage 3; see RULE_19
  msof_stage3 u_stage3 (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .in_data(m_res),
    .in_valid(m_done & m_acq),
    .filt_en(st_reg.lfil_en & ~vpeak_active),
    .avg_en(st_reg.avg & ~vpeak_active),
    .lower(st_reg.lower),
    .upper(st_reg.upper),
    .out_data(out_data),
    .out_valid(out_valid),
    .path(path_code)
  );

  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL: begin
        rd_val[CTRL_CONT] = st_reg.cont;
        rd_val[CTRL_ATC] = st_reg.atc;
        rd_val[CTRL_AVG] = st_reg.avg;
        rd_val[CTRL_AUTORC] = st_reg.autorc;
        rd_val[CTRL_LIM] = st_reg.lim_en;
        rd_val[CTRL_LFIL] = st_reg.lfil_en;
        rd_val[CTRL_RES_LSB +: 4] = st_reg.resol;
      end
      OFS_MATH: rd_val[7:0] = st_reg.math_en ? ASCII_1 : ASCII_0; // see RULE_23
      OFS_CMD: rd_val = '0;
      OFS_STATUS: begin
        rd_val[ST_PENDING] = st_reg.pending;
        rd_val[ST_MEASURING] = st_reg.measuring;
        rd_val[ST_ABORT_WAIT] = st_reg.abort_wait;
        rd_val[ST_VALID] = st_reg.result_valid;
        rd_val[ST_FAIL] = st_reg.last_fail;
        rd_val[ST_VPEAK] = vpeak_active;
        rd_val[ST_DIGITS_LSB +: 4] = digits;
      end
      OFS_SCALE: rd_val = st_reg.scale;
      OFS_OFFSET: rd_val = st_reg.offset;
      OFS_LOWER: rd_val = st_reg.lower;
      OFS_UPPER: rd_val = st_reg.upper;
      OFS_RESULT, OFS_RECALC: begin
        // NaN stands in for a missing or conflicting result; see RULE_15
        rd_val = (vpeak_active | ~st_reg.result_valid) ? NAN_VALUE : m_res; // see RULE_16
      end
      OFS_ERR: rd_val[15:0] = st_reg.err;
      OFS_COUNTS: rd_val = {st_reg.fail_cnt, st_reg.pass_cnt};
      OFS_PATH: rd_val[7:0] = path_code; // see RULE_11
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.start_q = 1'b0;
    st_next.abort_q = 1'b0;
    st_next.waited = access & ~stall & ~pready;
    if (psel) begin
      st_next.rdata = rd_val;
    end
    if (calc_go) begin
      st_next.calc_req = 1'b0;
    end
    // Abort is complete only after the engine reports idle; see RULE_01
    if (st_reg.abort_wait && !meas_busy && !st_reg.abort_q) begin
      st_next.abort_wait = 1'b0;
    end
    if (acq) begin
      st_next.raw = meas_data;
      st_next.measuring = 1'b0; // see RULE_25
      st_next.pending = 1'b0;
    end
    if (xfer && !pwrite && paddr == OFS_ERR) begin
      st_next.err = ERR_NONE;
    end
    if (xfer && pwrite) begin
      unique case (paddr)
        OFS_CTRL: begin
          st_next.cont = pwdata[CTRL_CONT];
          st_next.atc = pwdata[CTRL_ATC];
          st_next.avg = pwdata[CTRL_AVG];
          st_next.autorc = pwdata[CTRL_AUTORC];
          st_next.lim_en = pwdata[CTRL_LIM];
          st_next.lfil_en = pwdata[CTRL_LFIL];
          st_next.resol = pwdata[CTRL_RES_LSB +: 4];
          st_next.calc_req = st_reg.calc_req | st_reg.autorc; // see RULE_20
        end
        OFS_MATH: begin
          st_next.math_en = pwdata[0];
          st_next.fail_cnt = '0; // see RULE_22
          st_next.pass_cnt = '0;
        end
        OFS_SCALE: st_next.scale = pwdata;
        OFS_OFFSET: st_next.offset = pwdata;
        OFS_LOWER: begin
          st_next.lower = pwdata;
          st_next.calc_req = st_reg.calc_req | st_reg.autorc; // see RULE_20
        end
        OFS_UPPER: begin
          st_next.upper = pwdata;
          st_next.calc_req = st_reg.calc_req | st_reg.autorc; // see RULE_20
        end
        OFS_CMD: begin
          if (pwdata[CMD_INIT] && !st_reg.pending && !st_reg.abort_wait) begin
            st_next.start_q = 1'b1;
            st_next.pending = 1'b1;
            st_next.measuring = 1'b1; // see RULE_25
          end
          // Idle with continuous off is a no-op; see RULE_03
          if (pwdata[CMD_ABORT] && (st_reg.cont || st_reg.pending || st_reg.measuring)) begin
            st_next.abort_q = 1'b1; // see RULE_01
            st_next.abort_wait = 1'b1;
            st_next.start_q = 1'b0;
            // Single, block and repetitive cases all drop pending; see RULE_04, RULE_06
            st_next.pending = 1'b0; // see RULE_02
            st_next.measuring = 1'b0; // see RULE_07
            st_next.result_valid = 1'b0; // see RULE_08
          end
          if (pwdata[CMD_RECALC]) begin
            st_next.calc_req = 1'b1; // see RULE_19
          end
          if (pwdata[CMD_RESET]) begin
            st_next.cont = 1'b0;
            st_next.atc = 1'b0;
            st_next.avg = 1'b0;
            st_next.lim_en = 1'b0;
            st_next.lfil_en = 1'b0;
            st_next.resol = '0;
            st_next.autorc = AUTORC_CMD_RST; // see RULE_21
            st_next.math_en = MATH_RST; // see RULE_22
            st_next.fail_cnt = '0;
            st_next.pass_cnt = '0;
            st_next.scale = SCALE_RST;
            st_next.offset = OFFSET_RST;
            st_next.lower = LOWER_RST;
            st_next.upper = UPPER_RST;
          end
        end
        default: begin
        end
      endcase
      // Math settings are relevant state: recompute or invalidate; see RULE_10
      if (paddr == OFS_MATH || paddr == OFS_SCALE || paddr == OFS_OFFSET) begin
        if (st_reg.autorc) begin
          st_next.calc_req = 1'b1; // see RULE_20
        end else begin
          st_next.result_valid = 1'b0;
        end
      end
    end
    if (setup && rd_rc) begin
      st_next.calc_req = 1'b1; // see RULE_19
    end
    // A new result is valid until superseded, aborted or invalidated by a math setting write; see RULE_10
    if (m_done) begin
      st_next.result_valid = 1'b1;
      if (eff_lim) begin
        st_next.last_fail = out_range;
        // Counts only move on acquired data, never on recalculation; see RULE_19
        if (m_acq && out_range) begin
          st_next.fail_cnt = st_next.fail_cnt + 1'b1;
        end else if (m_acq) begin
          st_next.pass_cnt = st_next.pass_cnt + 1'b1;
        end
      end
    end
    if (xfer && (rd_res || rd_rc)) begin
      if (vpeak_active) begin
        st_next.err = ERR_CONFLICT; // see RULE_16
      end else if (!st_reg.result_valid) begin
        st_next.err = ERR_NODATA; // see RULE_15
      end
    end
    // Continuous mode restarts once any abort has finished; see RULE_05
    if (st_next.cont && !st_next.pending && !st_next.abort_wait && !st_next.start_q) begin
      st_next.start_q = 1'b1;
      st_next.pending = 1'b1;
      st_next.measuring = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_RST;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign meas_start = st_reg.start_q;
  assign meas_abort = st_reg.abort_q;
  assign block_mode = st_reg.atc & st_reg.avg & ~st_reg.cont; // see RULE_06
  assign pending_flag = st_reg.pending;
  assign measuring = st_reg.measuring;

  default clocking msof_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);

  a_abort_clears_flags: assert property (meas_abort |-> !pending_flag && !measuring) // RULE_02
    else $error("abort left pending or measuring set");
  a_abort_waits_stop: assert property (st_reg.abort_wait && meas_busy |=> st_reg.abort_wait) // RULE_01
    else $error("abort completed while engine busy");
  a_abort_idle_noop: assert property (xfer && pwrite && paddr == OFS_CMD && !st_reg.cont
    && !st_reg.pending && !st_reg.measuring |=> !meas_abort) // RULE_03
    else $error("abort acted while idle");
  a_abort_invalidates: assert property (meas_abort && !$past(m_done) |-> !st_reg.result_valid) // RULE_08
    else $error("aborted result still valid");
  a_cont_restart: assert property ($fell(st_reg.abort_wait) && st_reg.cont |-> meas_start
    && pending_flag) // RULE_05
    else $error("continuous mode did not restart");
  a_holdoff_stall: assert property (hold_math |-> !pready) // RULE_18
    else $error("result answered during holdoff");
  a_nodata_nan: assert property (xfer && rd_res && !vpeak_active && !st_reg.result_valid
    |-> prdata == NAN_VALUE ##1 st_reg.err == ERR_NODATA) // RULE_15
    else $error("missing result not flagged");
  a_vpeak_nan: assert property (xfer && (rd_res || rd_rc) && vpeak_active
    |-> prdata == NAN_VALUE ##1 st_reg.err == ERR_CONFLICT) // RULE_16
    else $error("voltage-peak query not flagged");
  a_recalc_counts: assert property (m_done && !m_acq && !(xfer && pwrite)
    |=> $stable(st_reg.fail_cnt) && $stable(st_reg.pass_cnt)) // RULE_19
    else $error("recalculation changed limit counts");
  a_math_clears: assert property (xfer && pwrite && paddr == OFS_MATH && !m_done
    |=> st_reg.fail_cnt == '0 && st_reg.pass_cnt == '0) // RULE_22
    else $error("math update kept limit counts");
  a_digits_range: assert property (digits >= DIGITS_MIN && digits <= DIGITS_MAX) // RULE_17
    else $error("digit count out of range");
  a_meas_done_clr: assert property (acq && !st_reg.cont |=> !measuring) // RULE_25
    else $error("measuring stayed set after completion");
  a_math_bool: assert property (xfer && !pwrite && paddr == OFS_MATH
    |-> prdata == {24'h000000, ASCII_0} || prdata == {24'h000000, ASCII_1}) // RULE_23
    else $error("boolean answer not ASCII");

  c_abort_cont: cover property (meas_abort && st_reg.cont);
  c_holdoff: cover property (hold_math ##[1:50] pready);
  c_recalc_query: cover property (xfer && rd_rc && st_reg.result_valid);
  c_block_abort: cover property (meas_abort && block_mode);
endmodule

// ===== core/msof_math.sv
// Purpose: Stage 1 scale/offset math with one register stage
// Assumes: Scale is signed fixed point with FRAC fraction bits
// Notes: Tag travels with the data so the caller knows its source
module msof_math #(
  parameter int W = msof_pkg::DATA_W,
  parameter int FRAC = msof_pkg::FRAC_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic calc,
  input wire logic calc_acq,
  input wire logic math_on,
  input wire logic [W-1:0] din,
  input wire logic [W-1:0] scale,
  input wire logic [W-1:0] offset,
  output logic [W-1:0] result,
  output logic done,
  output logic done_acq
);
  import msof_pkg::*;

  typedef struct packed {
    logic [W-1:0] result;
    logic done;
    logic acq;
  } msof_math_st_type;

  msof_math_st_type st_reg;
  msof_math_st_type st_next;
  logic signed [2*W-1:0] prod;

  assign prod = $signed(din) * $signed(scale);

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (calc) begin
      // Only operation offered is value times scale plus offset; see RULE_14
      if (math_on) begin
        st_next.result = W'(prod >>> FRAC) + offset;
      end else begin
        st_next.result = din;
      end
      st_next.done = 1'b1;
      st_next.acq = calc_acq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign result = st_reg.result;
  assign done = st_reg.done;
  assign done_acq = st_reg.acq;
endmodule

// ===== core/msof_stage3.sv
// Purpose: Stage 3, limit filter followed by averaging
// Assumes: Bounds are shared with the limit test
// Notes: Each sub-block passes data through untouched while disabled
module msof_stage3 #(
  parameter int W = msof_pkg::DATA_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  input wire logic filt_en,
  input wire logic avg_en,
  input wire logic [W-1:0] lower,
  input wire logic [W-1:0] upper,
  output logic [W-1:0] out_data,
  output logic out_valid,
  output logic [7:0] path
);
  import msof_pkg::*;

  typedef struct packed {
    logic [W-1:0] filt;
    logic filt_v;
    logic [W-1:0] avg;
    logic avg_v;
    logic primed;
  } msof_s3_st_type;

  msof_s3_st_type st_reg;
  msof_s3_st_type st_next;
  logic signed [W:0] sum;

  assign sum = $signed({st_reg.avg[W-1], st_reg.avg}) + $signed({st_reg.filt[W-1], st_reg.filt});

  always_comb begin
    st_next = st_reg;
    st_next.filt_v = in_valid;
    st_next.avg_v = st_reg.filt_v;
    // Serial sub-blocks, filter feeds averager; see RULE_11
    if (in_valid) begin
      st_next.filt = in_data;
      if (filt_en && $signed(in_data) < $signed(lower)) begin // see RULE_13
        st_next.filt = lower;
      end else if (filt_en && $signed(in_data) > $signed(upper)) begin
        st_next.filt = upper;
      end
    end
    if (st_reg.filt_v) begin
      st_next.primed = avg_en;
      // First sample after enabling has nothing to average with
      if (avg_en && st_reg.primed) begin // see RULE_13
        st_next.avg = sum[W:1];
      end else begin
        st_next.avg = st_reg.filt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign out_data = st_reg.avg;
  assign out_valid = st_reg.avg_v;
  assign path = PATH_FILT_AVG; // see RULE_11
endmodule

// ===== shared/msof_pkg.sv
// Purpose: Shared constants for the measurement abort and scale/offset block
// Assumes: APB register bus with 32-bit data, one aligned word per register
// Notes: Error codes are 16-bit two's complement values
package msof_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FRAC_BITS = 16;
  localparam int CNT_W = 16;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MATH = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SCALE = 8'h10;
  localparam logic [7:0] OFS_OFFSET = 8'h14;
  localparam logic [7:0] OFS_LOWER = 8'h18;
  localparam logic [7:0] OFS_UPPER = 8'h1c;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_RECALC = 8'h24;
  localparam logic [7:0] OFS_ERR = 8'h28;
  localparam logic [7:0] OFS_COUNTS = 8'h2c;
  localparam logic [7:0] OFS_PATH = 8'h30;

  localparam int CTRL_CONT = 0;
  localparam int CTRL_ATC = 1;
  localparam int CTRL_AVG = 2;
  localparam int CTRL_AUTORC = 3;
  localparam int CTRL_LIM = 4;
  localparam int CTRL_LFIL = 5;
  localparam int CTRL_RES_LSB = 8;

  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RECALC = 2;
  localparam int CMD_RESET = 3;

  localparam int ST_PENDING = 0;
  localparam int ST_MEASURING = 1;
  localparam int ST_ABORT_WAIT = 2;
  localparam int ST_VALID = 3;
  localparam int ST_FAIL = 4;
  localparam int ST_VPEAK = 5;
  localparam int ST_DIGITS_LSB = 8;

  localparam logic [31:0] SCALE_RST = 32'h0001_0000;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [31:0] LOWER_RST = 32'h0000_0000;
  localparam logic [31:0] UPPER_RST = 32'h0000_0000;
  localparam logic AUTORC_POWERUP = 1'b1;
  localparam logic AUTORC_CMD_RST = 1'b0;
  localparam logic MATH_RST = 1'b0;

  // Single-precision pattern of 9.91E37
  localparam logic [31:0] NAN_VALUE = 32'h7e95_1b72;
  // -230 and -221
  localparam logic [15:0] ERR_NODATA = 16'hff1a;
  localparam logic [15:0] ERR_CONFLICT = 16'hff23;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [7:0] ASCII_0 = 8'h30;
  localparam logic [7:0] ASCII_1 = 8'h31;
  localparam logic [3:0] DIGITS_MIN = 4'h1;
  localparam logic [3:0] DIGITS_MAX = 4'hf;
  // Stage 3 order: limit filter first, then averaging
  localparam logic [7:0] PATH_FILT_AVG = 8'h01;
endpackage

// ===== tb/msof_engine.sv
// Purpose: Measurement engine model facing the control block
// Assumes: Start and abort are one-cycle pulses on pclk
// Notes: Data churns outside the done pulse
module msof_engine #(
  parameter int DUR = 20,
  parameter logic [31:0] VAL = 32'h0000_0100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic meas_start,
  input wire logic meas_abort,
  output logic meas_busy,
  output logic meas_done,
  output logic [31:0] meas_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic abt;
  logic [31:0] junk;
  assign meas_data = meas_done ? VAL : junk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      abt <= 1'b0;
      meas_busy <= 1'b0;
      meas_done <= 1'b0;
      junk <= 32'h0000_0000;
    end else begin
      meas_done <= 1'b0;
      junk <= junk + 32'h9e37_79b9;
      if (meas_start) begin
        meas_busy <= 1'b1;
        abt <= 1'b0;
        cnt <= DUR;
      end else if (meas_abort && meas_busy) begin
        // Stopping is not instant, so the abort wait is exercised
        abt <= 1'b1;
        cnt <= 3;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        meas_busy <= 1'b0;
        meas_done <= !abt;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the measurement control block
// Assumes: Engine model answers every start; clock enable held high
// Notes: Scale is Q16.16, so 2.0 is 0x20000
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import msof_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic vpeak_active = 1'b0;
  logic dev_clear = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata, meas_data, rd, out_data;
  logic pready, pslverr, perr, meas_busy, meas_done, meas_start, meas_abort;
  logic block_mode, pending_flag, measuring, out_valid;
  int num_errors = 0;
  int tests_run = 0;
  msof_ctrl dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .meas_busy, .meas_done, .meas_data, .vpeak_active,
    .dev_clear, .meas_start, .meas_abort, .block_mode, .pending_flag, .measuring,
    .out_data, .out_valid);
  msof_engine eng (.pclk, .presetn, .meas_start, .meas_abort, .meas_busy, .meas_done,
    .meas_data);
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    // Each transfer is a whole message; no equation query is ever sent
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    rd = prdata;
    perr = pslverr;
    if (pready !== 1'b1) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic settle();
    int n;
    n = 0;
    while ((measuring !== 1'b0 || meas_busy !== 1'b0) && n < 200) begin
      @(posedge pclk);
      n++;
    end
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_reset();
    rdc(OFS_CTRL, 32'h8, 32'hff);
    rdc(OFS_MATH, {24'h0, ASCII_0});
    rdc(OFS_PATH, {24'h0, PATH_FILT_AVG});
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, perr}, 32'h1);
    wr(OFS_CMD, 32'h2);
    rdc(OFS_STATUS, 32'h0, 32'h0f);
  endtask
  task automatic t_single();
    wr(OFS_SCALE, 32'h0002_0000);
    wr(OFS_OFFSET, 32'h0000_0010);
    wr(OFS_MATH, 32'h1);
    rdc(OFS_MATH, {24'h0, ASCII_1});
    wr(OFS_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    check({30'h0, pending_flag, measuring}, 32'h3);
    rdc(OFS_RESULT, 32'h0000_0210);
    check({31'h0, measuring}, 32'h0);
    wr(OFS_OFFSET, 32'h0000_0020);
    settle();
    rdc(OFS_RESULT, 32'h0000_0220);
    check(out_data, 32'h0000_0210);
    wr(OFS_CMD, 32'h2);
    rdc(OFS_RESULT, 32'h0000_0220);
  endtask
  task automatic t_abort(input logic [31:0] ctrl);
    wr(OFS_CTRL, ctrl);
    wr(OFS_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    check({31'h0, block_mode}, {31'h0, ctrl[2]});
    wr(OFS_CMD, 32'h2);
    rdc(OFS_STATUS, 32'h0, 32'h0b);
    check({31'h0, meas_busy}, 32'h0);
    rdc(OFS_RESULT, NAN_VALUE);
    rdc(OFS_ERR, {16'h0, ERR_NODATA}, 32'hffff);
    settle();
  endtask
  task automatic t_cont();
    int n;
    n = 0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CMD, 32'h1);
    repeat (4) @(posedge pclk);
    wr(OFS_CMD, 32'h2);
    while (meas_start !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    check({30'h0, pending_flag, measuring}, 32'h3);
    dev_clear <= 1'b1;
    rdc(OFS_RESULT, NAN_VALUE);
    dev_clear <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    settle();
  endtask
  task automatic t_misc();
    vpeak_active <= 1'b1;
    rdc(OFS_RESULT, NAN_VALUE);
    rdc(OFS_ERR, {16'h0, ERR_CONFLICT}, 32'hffff);
    vpeak_active <= 1'b0;
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CMD, 32'h8);
    rdc(OFS_CTRL, 32'h0, 32'h8);
    rdc(OFS_RECALC, 32'h0000_0100);
    rdc(OFS_MATH, {24'h0, ASCII_0});
  endtask
  initial begin
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_abort(32'h0);
    t_abort(32'h6);
    t_cont();
    t_misc();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
